// >>> rtl/imp_pkg.sv
// Constants for the interrupt mask, priority and pending stage
package imp_pkg;

    // ------------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------------
    localparam logic [31:0] ADDR_SOURCE_MASK = 32'h4a000008;
    localparam logic [31:0] ADDR_PRIO_CTRL   = 32'h4a00000c;
    localparam logic [31:0] ADDR_WIN_PEND    = 32'h4a000010;
    localparam logic [31:0] ADDR_EVT_STATUS  = 32'h4a000020;
    localparam logic [31:0] ADDR_EVT_MASK    = 32'h4a000024;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [31:0] RST_SOURCE_MASK = 32'hffffffff;
    localparam logic [20:0] RST_PRIO_CTRL   = 21'h00007f;
    localparam logic [31:0] RST_WIN_PEND    = 32'h00000000;
    localparam logic [1:0]  RST_EVT         = 2'h0;

    // ------------------------------------------------------------------
    // Priority control field layout
    // ------------------------------------------------------------------
    localparam int PRIO_W       = 21;
    localparam int ROT_LSB      = 0;
    localparam int SEL_LSB      = 7;
    localparam int SEL_W        = 2;
    localparam int NUM_ARB      = 7;
    localparam int FINAL_ARB    = 6;

    // ------------------------------------------------------------------
    // Arbiter tree shape
    // ------------------------------------------------------------------
    localparam int NUM_SRC      = 32;
    localparam int NUM_GRP      = 6;
    localparam int ARB_INPUTS   = 6;
    localparam int EDGE_GRP_SZ  = 4;
    localparam int MID_GRP_SZ   = 6;
    localparam int LAST_GRP     = 5;

    // ------------------------------------------------------------------
    // Event status bits
    // ------------------------------------------------------------------
    localparam int EVT_WIN_LATCH = 0;
    localparam int EVT_FAST_DUP  = 1;
    localparam int EVT_W         = 2;

endpackage : imp_pkg

// >>> rtl/imp_top.sv
// Interrupt mask, rotating priority tree and one-hot pending stage
// Summary of operation
// - One mask bit per source, same positions
// - Masked sources never reach arbitration
// - Unmasked pending normal-mode sources compete and get serviced
// - Mask resets to all ones
// - Priority control resets to 0x7f
// - Six-input arbiters rotate inputs one to four
// - Four-input arbiters rotate inputs one to four
// - Rotate-enable bit per arbiter, bits zero-six
// - Pending bit only for arbitration winner
// - Pending one-hot or zero, drives normal request
// - Software reads pending to find serviced source
// - Writing ones clears pending bits
// - Fast-mode sources never set pending
// - Pending resets to zero
// - Raw pending bit is a waiting request
// - Unmasked pending fast-mode source drives fast request
`timescale 1ns/1ps

module imp_top #(
    parameter int NSRC = 32
) (
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Source pending and mode stages
    input  wire logic [NSRC-1:0]   raw_source_pending,
    input  wire logic [NSRC-1:0]   fast_normal_mode_select,
    // Processor requests
    output logic                   normal_interrupt_request,
    output logic                   fast_interrupt_request,
    // Block event interrupt
    output logic                   event_irq
);

    // ------------------------------------------------------------------
    // Arbiter helpers
    // ------------------------------------------------------------------
    // Source feeding input i of group g, or -1 when the input is unused
    function automatic int src_of(input int g, input int i);
        if (g == 0)
            return (i >= 1 && i <= imp_pkg::EDGE_GRP_SZ) ? i - 1 : -1;
        if (g == imp_pkg::LAST_GRP)
            return (i >= 1 && i <= imp_pkg::EDGE_GRP_SZ)
                ? imp_pkg::NUM_SRC - imp_pkg::EDGE_GRP_SZ + i - 1 : -1;
        return imp_pkg::EDGE_GRP_SZ + imp_pkg::MID_GRP_SZ * (g - 1) + i;
    endfunction : src_of

    // Input 0 first, then 1..4 starting at sel+1, input 5 last
    function automatic logic [3:0] imp_arb(input logic [5:0] req,
                                           input logic [1:0] sel);
        logic [3:0] res;
        logic [2:0] in;
        res = 4'h0;
        in  = 3'h0;
        if (req[5])
            res = 4'hd;
        for (int k = 3; k >= 0; k--) begin
            in = 3'(((int'(sel) + k) % 4) + 1);
            if (req[in])
                res = {1'b1, in};
        end
        if (req[0])
            res = 4'h8;
        return res;
    endfunction : imp_arb

    function automatic logic [1:0] sel_of(input logic [20:0] ctl, input int k);
        return ctl[imp_pkg::SEL_LSB + imp_pkg::SEL_W * k +: imp_pkg::SEL_W];
    endfunction : sel_of

    // ------------------------------------------------------------------
    // Registers and bus decode
    // ------------------------------------------------------------------
    logic [NSRC-1:0]              source_mask;
    logic [imp_pkg::PRIO_W-1:0]   arbiter_priority_control;
    logic [NSRC-1:0]              winning_request_pending;
    logic [NSRC-1:0]              next_pending;
    logic [imp_pkg::EVT_W-1:0]    evt_status;
    logic [imp_pkg::EVT_W-1:0]    evt_mask;
    logic [imp_pkg::EVT_W-1:0]    evt_set;
    logic [2:0]                   win_grp;
    logic [2:0]                   win_in;
    logic                         wr_en;
    logic                         setup_rd;
    logic                         hit;
    logic                         wr_mask;
    logic                         wr_prio;
    logic                         wr_pend;
    logic                         wr_estat;
    logic                         wr_emask;
    logic                         svc;
    logic [31:0]                  rd_data;

    assign wr_en    = psel && penable && pwrite;
    assign setup_rd = psel && !penable && !pwrite;
    assign hit      = paddr == imp_pkg::ADDR_SOURCE_MASK
                   || paddr == imp_pkg::ADDR_PRIO_CTRL
                   || paddr == imp_pkg::ADDR_WIN_PEND
                   || paddr == imp_pkg::ADDR_EVT_STATUS
                   || paddr == imp_pkg::ADDR_EVT_MASK;
    assign wr_mask  = wr_en && paddr == imp_pkg::ADDR_SOURCE_MASK;
    assign wr_prio  = wr_en && paddr == imp_pkg::ADDR_PRIO_CTRL;
    assign wr_pend  = wr_en && paddr == imp_pkg::ADDR_WIN_PEND;
    assign wr_estat = wr_en && paddr == imp_pkg::ADDR_EVT_STATUS;
    assign wr_emask = wr_en && paddr == imp_pkg::ADDR_EVT_MASK;
    // Service ends when software clears a bit that is actually set
    assign svc      = wr_pend && |(winning_request_pending & pwdata);

    // Zero wait states; unmapped addresses answer with an error
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !hit;

    // ------------------------------------------------------------------
    // Request qualification
    // ------------------------------------------------------------------
    logic [NSRC-1:0] cand;
    logic [NSRC-1:0] fast_cand;

    // Raw pending stays a request until cleared upstream
    assign cand      = raw_source_pending & ~source_mask & ~fast_normal_mode_select;
    assign fast_cand = raw_source_pending & ~source_mask & fast_normal_mode_select;

    // ------------------------------------------------------------------
    // Arbiter tree
    // ------------------------------------------------------------------
    logic [imp_pkg::NUM_GRP-1:0][imp_pkg::ARB_INPUTS-1:0] grp_req;
    logic [imp_pkg::NUM_GRP-1:0][3:0]                     grp_pick;
    logic [imp_pkg::NUM_GRP-1:0]                          fin_req;
    logic [3:0]                                           fin_pick;
    logic [2:0]                                           fin_grp;
    logic [2:0]                                           fin_in;
    logic [4:0]                                           win_src;

    for (genvar g = 0; g < imp_pkg::NUM_GRP; g++) begin : grp
        for (genvar i = 0; i < imp_pkg::ARB_INPUTS; i++) begin : inp
            localparam int S = src_of(g, i);
            if (S >= 0) begin : used
                assign grp_req[g][i] = cand[S];
            end else begin : unused
                assign grp_req[g][i] = 1'b0;
            end
        end
        assign grp_pick[g] = imp_arb(grp_req[g], sel_of(arbiter_priority_control, g));
        assign fin_req[g]  = grp_pick[g][3];
    end

    assign fin_pick = imp_arb(fin_req, sel_of(arbiter_priority_control, imp_pkg::FINAL_ARB));
    assign fin_grp  = fin_pick[2:0];
    assign fin_in   = grp_pick[fin_grp][2:0];
    assign win_src  = 5'(src_of(int'(fin_grp), int'(fin_in)));

    // ------------------------------------------------------------------
    // Mask register
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            source_mask <= imp_pkg::RST_SOURCE_MASK;
        else if (wr_mask)
            source_mask <= pwdata;
    end

    // ------------------------------------------------------------------
    // Priority control with rotation on service
    // ------------------------------------------------------------------
    // A software write in the same cycle overrides the rotation
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            arbiter_priority_control <= imp_pkg::RST_PRIO_CTRL;
        end else if (wr_prio) begin
            arbiter_priority_control <= pwdata[imp_pkg::PRIO_W-1:0];
        end else if (svc) begin
            if (arbiter_priority_control[imp_pkg::ROT_LSB + int'(win_grp)]
                && win_in >= 3'h1 && win_in <= 3'h4)
                arbiter_priority_control[imp_pkg::SEL_LSB + imp_pkg::SEL_W * int'(win_grp)
                    +: imp_pkg::SEL_W] <= win_in[1:0];
            if (arbiter_priority_control[imp_pkg::ROT_LSB + imp_pkg::FINAL_ARB]
                && win_grp >= 3'h1 && win_grp <= 3'h4)
                arbiter_priority_control[imp_pkg::SEL_LSB + imp_pkg::SEL_W * imp_pkg::FINAL_ARB
                    +: imp_pkg::SEL_W] <= win_grp[1:0];
        end
    end

    // ------------------------------------------------------------------
    // Winning request pending
    // ------------------------------------------------------------------
    // Latch only while empty so at most one bit is ever set
    always_comb begin
        next_pending = winning_request_pending;
        if (wr_pend)
            next_pending = next_pending & ~pwdata;
        if (winning_request_pending == '0 && fin_pick[3])
            next_pending = NSRC'(1) << win_src;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            winning_request_pending <= imp_pkg::RST_WIN_PEND;
        else
            winning_request_pending <= next_pending;
    end

    // Served group and input, kept for rotation
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            win_grp <= 3'h0;
            win_in  <= 3'h0;
        end else if (winning_request_pending == '0 && fin_pick[3]) begin
            win_grp <= fin_grp;
            win_in  <= fin_in;
        end
    end

    assign normal_interrupt_request = |winning_request_pending;

    // ------------------------------------------------------------------
    // Fast request
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            fast_interrupt_request <= 1'b0;
        else
            fast_interrupt_request <= |fast_cand;
    end

    // ------------------------------------------------------------------
    // Block events
    // ------------------------------------------------------------------
    // More than one fast source breaks the single fast-slot assumption
    assign evt_set[imp_pkg::EVT_WIN_LATCH] = winning_request_pending == '0 && fin_pick[3];
    assign evt_set[imp_pkg::EVT_FAST_DUP]  =
        (fast_normal_mode_select & (fast_normal_mode_select - NSRC'(1))) != '0;

    // Set wins over a same-cycle write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            evt_status <= imp_pkg::RST_EVT;
        else if (wr_estat)
            evt_status <= (evt_status & ~pwdata[imp_pkg::EVT_W-1:0]) | evt_set;
        else
            evt_status <= evt_status | evt_set;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            evt_mask <= imp_pkg::RST_EVT;
        else if (wr_emask)
            evt_mask <= pwdata[imp_pkg::EVT_W-1:0];
    end

    assign event_irq = |(evt_status & evt_mask);

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    always_comb begin
        rd_data = 32'h0;
        case (paddr)
            imp_pkg::ADDR_SOURCE_MASK: rd_data = source_mask;
            imp_pkg::ADDR_PRIO_CTRL:   rd_data = 32'(arbiter_priority_control);
            imp_pkg::ADDR_WIN_PEND:    rd_data = winning_request_pending;
            imp_pkg::ADDR_EVT_STATUS:  rd_data = 32'(evt_status);
            imp_pkg::ADDR_EVT_MASK:    rd_data = 32'(evt_mask);
            default:                   rd_data = 32'h0;
        endcase
    end

    // Captured in setup so access phase returns a flip-flop value
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            prdata <= 32'h0;
        else if (setup_rd)
            prdata <= rd_data;
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Pending one cycle back, so new bits can be told from held ones
    logic [NSRC-1:0] prev_pending;
    logic [NSRC-1:0] new_bits;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            prev_pending <= imp_pkg::RST_WIN_PEND;
        else
            prev_pending <= winning_request_pending;
    end

    assign new_bits = winning_request_pending & ~prev_pending;

    sequence serve_rot_s;
        svc && !wr_prio && arbiter_priority_control[int'(win_grp)]
            && win_in >= 3'h1 && win_in <= 3'h4;
    endsequence

    sequence serve_fixed_s;
        svc && !wr_prio && !arbiter_priority_control[int'(win_grp)];
    endsequence

    reset_values_a: assert property ($rose(presetn) |-> source_mask == '1
        && arbiter_priority_control == 21'h7f && winning_request_pending == '0)
        else $error("register reset values wrong");

    masked_blocked_a: assert property ((new_bits & $past(source_mask)) == '0)
        else $error("masked source reached pending");

    fast_excluded_a: assert property ((new_bits & $past(fast_normal_mode_select)) == '0)
        else $error("fast source reached pending");

    winner_raw_a: assert property ((new_bits & ~$past(raw_source_pending)) == '0)
        else $error("pending set without raw request");

    onehot_irq_a: assert property ($onehot0(winning_request_pending)
        && normal_interrupt_request == (winning_request_pending != '0))
        else $error("pending not one-hot or request mismatch");

    serviced_a: assert property (winning_request_pending == '0 && cand != '0
        |=> $onehot(winning_request_pending))
        else $error("unmasked request not latched");

    w1c_clear_a: assert property (wr_pend && winning_request_pending != '0
        |=> winning_request_pending == ($past(winning_request_pending) & ~$past(pwdata)))
        else $error("write-one clear wrong");

    rotate_order_a: assert property (serve_rot_s
        |=> sel_of(arbiter_priority_control, int'($past(win_grp))) == $past(win_in[1:0]))
        else $error("group order did not rotate");

    fixed_order_a: assert property (serve_fixed_s
        |=> sel_of(arbiter_priority_control, int'($past(win_grp)))
            == $past(sel_of(arbiter_priority_control, int'(win_grp))))
        else $error("fixed order changed");

    pend_read_a: assert property (setup_rd && paddr == imp_pkg::ADDR_WIN_PEND
        |=> prdata == $past(winning_request_pending))
        else $error("pending read mismatch");

    fast_route_a: assert property ((raw_source_pending & ~source_mask
        & fast_normal_mode_select) != '0 |=> fast_interrupt_request)
        else $error("fast request not raised");

    event_irq_a: assert property (evt_set[imp_pkg::EVT_WIN_LATCH] && evt_mask[0]
        && !wr_emask |=> event_irq)
        else $error("event interrupt missing");

    mask_write_a: assert property (wr_mask |=> source_mask == $past(pwdata))
        else $error("mask write not stored");

    prio_write_a: assert property (wr_prio
        |=> arbiter_priority_control == $past(pwdata[imp_pkg::PRIO_W-1:0]))
        else $error("priority write not stored");

    pend_hold_a: assert property (winning_request_pending != '0 && !wr_pend
        |=> winning_request_pending == $past(winning_request_pending))
        else $error("pending changed without clear");

    fast_drop_a: assert property ((raw_source_pending & ~source_mask
        & fast_normal_mode_select) == '0 |=> !fast_interrupt_request)
        else $error("fast request without source");

endmodule : imp_top

// >>> sim/imp_src_model.sv
// Behavioural source-pending and mode stages that feed the block
`timescale 1ns/1ps

module imp_src_model (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Source events, software clears and mode choice
    input  wire logic [31:0] src_req,
    input  wire logic [31:0] src_clr,
    input  wire logic [31:0] mode_in,
    // Toward the block
    output logic      [31:0] raw_source_pending,
    output logic      [31:0] fast_normal_mode_select
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            raw_source_pending <= 32'h0;
        end else begin
            // Set whatever the mask says; a new request beats a same-cycle clear
            raw_source_pending <= (raw_source_pending & ~src_clr) | src_req;
        end
    end

    // Plain level; the bench sets two bits only to provoke the fault event
    assign fast_normal_mode_select = mode_in;
endmodule : imp_src_model

// >>> sim/tb_top.sv
// Self-checking testbench for the mask, priority and pending stage
`timescale 1ns/1ps

module tb_top;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [31:0] raw;
    logic [31:0] mode;
    logic [31:0] src_req = 32'h0;
    logic [31:0] src_clr = 32'h0;
    logic [31:0] mode_in = 32'h0;
    logic        nreq;
    logic        freq;
    logic        event_irq;
    int          n_mismatch = 0;
    int          comparisons = 0;
    int          cycles = 0;
    localparam logic [31:0] MSK = imp_pkg::ADDR_SOURCE_MASK;
    localparam logic [31:0] PRI = imp_pkg::ADDR_PRIO_CTRL;
    localparam logic [31:0] PND = imp_pkg::ADDR_WIN_PEND;
    localparam logic [31:0] EST = imp_pkg::ADDR_EVT_STATUS;
    localparam logic [31:0] EMK = imp_pkg::ADDR_EVT_MASK;

    always #5 pclk = ~pclk;

    imp_src_model i_src (.pclk(pclk), .presetn(presetn), .src_req(src_req), .src_clr(src_clr),
        .mode_in(mode_in), .raw_source_pending(raw), .fast_normal_mode_select(mode));

    imp_top #(.NSRC(32)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .raw_source_pending(raw), .fast_normal_mode_select(mode),
        .normal_interrupt_request(nreq), .fast_interrupt_request(freq),
        .event_irq(event_irq));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // Hang guard: whole run needs well under a thousand cycles
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // Entered just after a rising edge; leaves one idle cycle behind it
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, a, d, rd, err);
    endtask : wr

    task automatic rdc(input string what, input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, a, 32'h0, rd, err);
        chk(what, rd, exp);
    endtask : rdc

    task automatic pulse(input logic [31:0] set, input logic [31:0] clr);
        src_req <= set;
        src_clr <= clr;
        @(posedge pclk);
        src_req <= 32'h0;
        src_clr <= 32'h0;
        @(posedge pclk);
    endtask : pulse

    // Outputs are judged mid-cycle, clear of the edge's updates
    task automatic look(input string what, input logic seen_sel, input logic exp);
        @(negedge pclk);
        chk(what, {31'h0, seen_sel ? freq : nreq}, {31'h0, exp});
        @(posedge pclk);
    endtask : look

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        logic [31:0] rd;
        logic        err;
        rdc("mask_rst", MSK, 32'hffffffff);
        rdc("prio_rst", PRI, 32'h0000007f);
        rdc("pend_rst", PND, 32'h00000000);
        rdc("evst_rst", EST, 32'h00000000);
        apb(1'b0, 32'h4a000030, 32'h0, rd, err);
        chk("unmapped_err", {31'h0, err}, 32'h1);
        wr(MSK, 32'h5a5a0f0f);
        rdc("mask_rw", MSK, 32'h5a5a0f0f);
        wr(MSK, 32'hffffffff);
        $display("test reset done");
    endtask : t_reset

    task automatic t_mask();
        pulse(32'h20, 32'h0);
        look("masked_nreq", 1'b0, 1'b0);
        chk("raw_set_masked", raw, 32'h20);
        rdc("pend_masked", PND, 32'h0);
        wr(MSK, 32'hffffffdf);
        look("open_nreq", 1'b0, 1'b1);
        rdc("pend_win", PND, 32'h20);
        wr(PND, 32'hffffffdf);
        rdc("pend_w0", PND, 32'h20);
        pulse(32'h0, 32'h20);
        wr(PND, 32'h20);
        rdc("pend_w1c", PND, 32'h0);
        look("clr_nreq", 1'b0, 1'b0);
        $display("test mask done");
    endtask : t_mask

    task automatic t_order();
        for (int g = 0; g < 2; g++) begin
            pulse(g ? 32'h3e0 : 32'h0f, 32'hffffffff);
            wr(MSK, g ? 32'hfffffc1f : 32'hfffffff0);
            for (int c = 0; c < 4; c++) begin
                wr(PRI, c << (g ? 9 : 7));
                wr(PND, 32'hffffffff);
                rdc("order", PND, g ? (32'h20 << c) : (32'h1 << c));
            end
        end
        pulse(32'h11, 32'h0);
        wr(MSK, 32'hfffffc0f);
        wr(PND, 32'hffffffff);
        rdc("input0_top", PND, 32'h10);
        wr(MSK, 32'hfffffc0e);
        wr(PRI, 32'h0);
        wr(PND, 32'hffffffff);
        rdc("final_arb", PND, 32'h1);
        pulse(32'h0, 32'hffffffff);
        wr(PND, 32'hffffffff);
        $display("test order done");
    endtask : t_order

    task automatic t_rotate();
        wr(PRI, 32'h7f);
        pulse(32'h3, 32'h0);
        wr(MSK, 32'hfffffffc);
        rdc("rot_first", PND, 32'h1);
        wr(PND, 32'h1);
        rdc("rot_second", PND, 32'h2);
        rdc("rot_field1", PRI, 32'h000000ff);
        wr(PND, 32'h2);
        rdc("rot_third", PND, 32'h1);
        rdc("rot_field2", PRI, 32'h0000017f);
        wr(PRI, 32'h7e);
        wr(PND, 32'h1);
        rdc("fixed_win", PND, 32'h1);
        rdc("fixed_field", PRI, 32'h0000007e);
        pulse(32'h0, 32'h3);
        wr(PND, 32'hffffffff);
        $display("test rotate done");
    endtask : t_rotate

    task automatic t_fast();
        mode_in <= 32'h8;
        pulse(32'h8, 32'h0);
        wr(MSK, 32'hfffffff7);
        look("fast_req", 1'b1, 1'b1);
        look("fast_no_nreq", 1'b0, 1'b0);
        rdc("fast_pend", PND, 32'h0);
        wr(MSK, 32'hffffffff);
        look("fast_masked", 1'b1, 1'b0);
        pulse(32'h0, 32'h8);
        $display("test fast done");
    endtask : t_fast

    task automatic t_event();
        wr(EST, 32'h3);
        rdc("evst_clr", EST, 32'h0);
        mode_in <= 32'h18;
        @(posedge pclk);
        rdc("evst_dup", EST, 32'h2);
        chk("irq_masked", {31'h0, event_irq}, 32'h0);
        wr(EMK, 32'h2);
        chk("irq_on", {31'h0, event_irq}, 32'h1);
        mode_in <= 32'h0;
        @(posedge pclk);
        wr(EST, 32'h2);
        chk("irq_off", {31'h0, event_irq}, 32'h0);
        pulse(32'h1, 32'h0);
        wr(MSK, 32'hfffffffe);
        rdc("evst_latch", EST, 32'h1);
        wr(EMK, 32'h3);
        chk("irq_latch", {31'h0, event_irq}, 32'h1);
        wr(EST, 32'h1);
        chk("irq_cleared", {31'h0, event_irq}, 32'h0);
        $display("test event done");
    endtask : t_event

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_mask();
        t_order();
        t_rotate();
        t_fast();
        t_event();
        tally_and_finish();
    end
endmodule : tb_top
